/* File: src/isr_map.vh */
// Register offsets, field positions and reset values of the interrupt block
`ifndef ISR_MAP_VH
`define ISR_MAP_VH
// Word addresses of the registers
`define ISR_OFS_RESET_CTRL 4'h0
`define ISR_OFS_IRQ_FIRST 4'h1
`define ISR_OFS_IRQ_SECOND 4'h2
`define ISR_OFS_IRQ_THIRD 4'h3
`define ISR_OFS_TIMER 4'h4
`define ISR_OFS_CONTEXT 4'h5
`define ISR_OFS_STATUS 4'h6
// Reset control register
`define ISR_RC_PRIO_EN 7
`define ISR_RC_SOFT_BOR 6
`define ISR_RC_UNUSED 5
`define ISR_RC_RST_INSTR 4
`define ISR_RC_WDT_TO 3
`define ISR_RC_PWR_DOWN 2
`define ISR_RC_POWER_ON 1
`define ISR_RC_BROWNOUT 0
// First control register
`define ISR_C1_GIE 7
`define ISR_C1_PERIPHERAL_IRQ_ENABLE 6
`define ISR_C1_T0IE 5
`define ISR_C1_X0IE 4
`define ISR_C1_PCIE 3
`define ISR_C1_T0IF 2
`define ISR_C1_X0IF 1
`define ISR_C1_PCIF 0
// Second control register
`define ISR_C2_EDGE0 6
`define ISR_C2_EDGE1 5
`define ISR_C2_EDGE2 4
`define ISR_C2_T0IP 2
`define ISR_C2_PCIP 0
// Third control register
`define ISR_C3_X2IP 7
`define ISR_C3_X1IP 6
`define ISR_C3_X2IE 4
`define ISR_C3_X1IE 3
`define ISR_C3_X2IF 1
`define ISR_C3_X1IF 0
// Timer control: write bit 16 selects 16-bit mode, bit 17 runs the timer
`define ISR_TM_WIDE 8
`define ISR_TM_RUN 9
`define ISR_C2_RESET 8'hF5
`define ISR_C3_RESET 8'hC0
`endif

/* File: src/isr_pin_sync.v */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module isr_pin_sync
#(
   parameter WIDTH = 1
)
(
   // Clock and reset
   input wire sys_clk_i,
   input wire rst_b_i,
   // Pins
   input wire [WIDTH-1:0] pin_i,
   output reg [WIDTH-1:0] level_o
);
   reg [WIDTH-1:0] s1;
   reg [WIDTH-1:0] s2;
   reg [WIDTH-1:0] s3;
   integer k;
   always @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         s1 <= {WIDTH{1'b0}};
         s2 <= {WIDTH{1'b0}};
         s3 <= {WIDTH{1'b0}};
         level_o <= {WIDTH{1'b0}};
      end
      else
      begin
         s1 <= pin_i;
         s2 <= s1;
         s3 <= s2;
         // Level moves only once stages two and three agree
         for (k = 0; k < WIDTH; k = k + 1)
         begin
            if (s2[k] == s3[k])
               level_o[k] <= s3[k];
         end
      end
   end
endmodule // isr_pin_sync

/* File: src/isr_ctrl.v */
// Interrupt sources, reset-cause flags and context save logic
`timescale 1ns/1ns
`include "isr_map.vh"
////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Priority enable bit selects two-level or single-level
// - Reset register records cause of reset/wake
// - Soft brownout bit resets from configuration strap
// - Power-on bit reset value follows reset type
// - Bit 5 of reset register reads zero
// - External pins edge-triggered, polarity bit selects edge
// - Valid edge sets flag; enable gates interrupt
// - Enabled external interrupt wakes from power-managed mode
// - After wake, vector if global enable, else resume
// - External one/two priority at third register bits 6,7
// - External zero always high priority
// - 8-bit mode: overflow FF to 00 sets flag
// - 16-bit mode: overflow FFFF to 0000 sets flag
// - Timer enable first reg bit 5, priority second bit 2
// - Port B pins 7..4 change sets flag bit 0
// - Change enable first reg bit 3, priority second bit 0
// - Entry pushes PC, shadows W, status, bank
// - Legacy mode needs peripheral enable for peripherals
module isr_ctrl
#(
   parameter PC_W = 21,
   parameter STACK_DEPTH = 31
)
(
   // Clock and reset
   input wire sys_clk_i,
   input wire rst_b_i,
   // Reset cause and configuration
   input wire cfg_soft_bor_i,
   input wire cause_por_i,
   input wire cause_bor_i,
   input wire cause_wdt_i,
   input wire cause_rst_instr_i,
   input wire sleep_i,
   // Pins
   input wire [2:0] ext_pin_i,
   input wire [3:0] portb_hi_i,
   input wire peripheral_irq_i,
   // Core context
   input wire irq_ack_i,
   input wire [PC_W-1:0] pc_i,
   input wire [7:0] working_accumulator_i,
   input wire [7:0] status_i,
   input wire [7:0] bsr_i,
   // Avalon-MM slave
   input wire [3:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   output reg [31:0] avs_readdata_o,
   output reg avs_waitrequest_o,
   // Core requests
   output reg irq_high_o,
   output reg irq_low_o,
   output reg wake_o,
   output reg vector_o
);
   reg [7:0] reset_cause_and_priority_control, c1, c2, c3;
   reg [15:0] tmr;
   reg tm_wide, tm_run, strap_done, sync_live, ack_seen;
   reg [23:0] shadow;
   reg [PC_W-1:0] stack_mem [0:STACK_DEPTH-1];
   reg [4:0] sp;
   reg [2:0] ext_prev, warm;
   reg [3:0] pb_prev;
   wire [2:0] ext_lvl, rise, fall, pol, ext_hit, x_en, x_pend;
   wire [3:0] pb_lvl;
   wire pb_hit, tmr_ovf, wr, rd, t0_pend, pc_pend, any_hi, any_lo, legacy;
   reg [31:0] next_rdata;

   isr_pin_sync #(.WIDTH(7)) u_sync
   (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .pin_i({portb_hi_i, ext_pin_i}),
      .level_o({pb_lvl, ext_lvl})
   );

   ////////////////////////////////////////////////////////////////////
   // Event detection
   assign pol = {c2[`ISR_C2_EDGE2], c2[`ISR_C2_EDGE1], c2[`ISR_C2_EDGE0]};
   assign rise = ext_lvl & ~ext_prev;
   assign fall = ~ext_lvl & ext_prev;
   // Edges ignored until the filter carries the real pin level
   assign ext_hit = sync_live ? ((pol & rise) | (~pol & fall)) : 3'h0;
   assign pb_hit = sync_live & (pb_lvl != pb_prev);
   assign tmr_ovf = tm_run & (tm_wide ? (tmr == 16'hFFFF) :
      (tmr[7:0] == 8'hFF));
   // Write lands at the edge that sees waitrequest low
   assign wr = avs_write_i & ~avs_waitrequest_o;
   assign rd = avs_read_i & avs_waitrequest_o;

   always @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         ext_prev <= 3'h0;
         pb_prev <= 4'h0;
         sync_live <= 1'b0;
         warm <= 3'h0;
      end
      else
      begin
         ext_prev <= ext_lvl;
         pb_prev <= pb_lvl;
         // A pin idling high would otherwise look like an edge
         if (warm != 3'h4)
            warm <= warm + 3'h1;
         else
            sync_live <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Reset control register
   // Cause flags caught by a clocked process after release
   always @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         reset_cause_and_priority_control <= 8'h00;
         strap_done <= 1'b0;
      end
      else if (!strap_done)
      begin
         strap_done <= 1'b1;
         reset_cause_and_priority_control[`ISR_RC_PRIO_EN] <= 1'b0;
         reset_cause_and_priority_control[`ISR_RC_SOFT_BOR] <= cfg_soft_bor_i;
         reset_cause_and_priority_control[`ISR_RC_UNUSED] <= 1'b0;
         reset_cause_and_priority_control[`ISR_RC_RST_INSTR] <= ~cause_rst_instr_i;
         reset_cause_and_priority_control[`ISR_RC_WDT_TO] <= ~cause_wdt_i;
         reset_cause_and_priority_control[`ISR_RC_PWR_DOWN] <= 1'b1;
         reset_cause_and_priority_control[`ISR_RC_POWER_ON] <= ~cause_por_i;
         reset_cause_and_priority_control[`ISR_RC_BROWNOUT] <= ~(cause_bor_i | cause_por_i);
      end
      else
      begin
         if (wr && avs_address_i == `ISR_OFS_RESET_CTRL)
         begin
            reset_cause_and_priority_control[`ISR_RC_PRIO_EN] <= avs_writedata_i[`ISR_RC_PRIO_EN];
            reset_cause_and_priority_control[`ISR_RC_SOFT_BOR] <= avs_writedata_i[`ISR_RC_SOFT_BOR];
            reset_cause_and_priority_control[`ISR_RC_RST_INSTR] <= avs_writedata_i[`ISR_RC_RST_INSTR];
            reset_cause_and_priority_control[`ISR_RC_POWER_ON] <= avs_writedata_i[`ISR_RC_POWER_ON];
            reset_cause_and_priority_control[`ISR_RC_BROWNOUT] <= avs_writedata_i[`ISR_RC_BROWNOUT];
         end
         // Sleep entry clears the power-down flag
         if (sleep_i)
            reset_cause_and_priority_control[`ISR_RC_PWR_DOWN] <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Control registers; hardware set beats software clear
   always @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         c1 <= 8'h00;
         c2 <= `ISR_C2_RESET;
         c3 <= `ISR_C3_RESET;
      end
      else
      begin
         if (wr && avs_address_i == `ISR_OFS_IRQ_FIRST)
            c1 <= avs_writedata_i[7:0];
         if (wr && avs_address_i == `ISR_OFS_IRQ_SECOND)
            c2 <= avs_writedata_i[7:0] & 8'hF5;
         if (wr && avs_address_i == `ISR_OFS_IRQ_THIRD)
            c3 <= avs_writedata_i[7:0] & 8'hDB;
         if (irq_ack_i)
            c1[`ISR_C1_GIE] <= 1'b0;
         if (ext_hit[0])
            c1[`ISR_C1_X0IF] <= 1'b1;
         if (ext_hit[1])
            c3[`ISR_C3_X1IF] <= 1'b1;
         if (ext_hit[2])
            c3[`ISR_C3_X2IF] <= 1'b1;
         if (tmr_ovf)
            c1[`ISR_C1_T0IF] <= 1'b1;
         if (pb_hit)
            c1[`ISR_C1_PCIF] <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Timer zero counter
   always @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         tmr <= 16'h0000;
         tm_wide <= 1'b0;
         tm_run <= 1'b0;
      end
      else if (wr && avs_address_i == `ISR_OFS_TIMER)
      begin
         tmr <= avs_writedata_i[15:0];
         tm_wide <= avs_writedata_i[16 + `ISR_TM_WIDE - 8];
         tm_run <= avs_writedata_i[16 + `ISR_TM_RUN - 8];
      end
      else if (tm_run)
      begin
         if (tm_wide)
            tmr <= tmr + 16'h0001;
         else
            tmr <= {tmr[15:8], tmr[7:0] + 8'h01};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Request routing
   assign legacy = ~reset_cause_and_priority_control[`ISR_RC_PRIO_EN];
   assign x_en = {c3[`ISR_C3_X2IE], c3[`ISR_C3_X1IE], c1[`ISR_C1_X0IE]};
   assign x_pend = x_en &
      {c3[`ISR_C3_X2IF], c3[`ISR_C3_X1IF], c1[`ISR_C1_X0IF]};
   assign t0_pend = c1[`ISR_C1_T0IE] & c1[`ISR_C1_T0IF];
   assign pc_pend = c1[`ISR_C1_PCIE] & c1[`ISR_C1_PCIF];
   // External zero has no priority bit
   assign any_hi = x_pend[0] |
      (x_pend[1] & c3[`ISR_C3_X1IP]) | (x_pend[2] & c3[`ISR_C3_X2IP]) |
      (t0_pend & c2[`ISR_C2_T0IP]) | (pc_pend & c2[`ISR_C2_PCIP]);
   assign any_lo = (x_pend[1] & ~c3[`ISR_C3_X1IP]) |
      (x_pend[2] & ~c3[`ISR_C3_X2IP]) |
      (t0_pend & ~c2[`ISR_C2_T0IP]) | (pc_pend & ~c2[`ISR_C2_PCIP]);

   always @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         irq_high_o <= 1'b0;
         irq_low_o <= 1'b0;
         wake_o <= 1'b0;
         vector_o <= 1'b0;
      end
      else if (legacy)
      begin
         // Single level: global bit gates all, peripheral bit only the peripheral request
         irq_high_o <= c1[`ISR_C1_GIE] & (any_hi | any_lo |
            (c1[`ISR_C1_PERIPHERAL_IRQ_ENABLE] & peripheral_irq_i));
         irq_low_o <= 1'b0;
         wake_o <= sleep_i & (|x_pend);
         vector_o <= sleep_i & (|x_pend) & c1[`ISR_C1_GIE];
      end
      else
      begin
         // Bit 7 gates high level, bit 6 gates low level
         irq_high_o <= c1[`ISR_C1_GIE] & any_hi;
         irq_low_o <= c1[`ISR_C1_GIE] & c1[`ISR_C1_PERIPHERAL_IRQ_ENABLE] &
            (any_lo | peripheral_irq_i);
         wake_o <= sleep_i & (|x_pend);
         vector_o <= sleep_i & (|x_pend) & c1[`ISR_C1_GIE];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Context save on interrupt entry
   always @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         shadow <= 24'h000000;
         sp <= 5'h00;
         ack_seen <= 1'b0;
      end
      else
      begin
         ack_seen <= irq_ack_i;
         // One save per acknowledge pulse; overflow stops pushes
         if (irq_ack_i && !ack_seen)
         begin
            shadow <= {working_accumulator_i, status_i, bsr_i};
            if (sp < STACK_DEPTH[4:0])
               sp <= sp + 5'h01;
         end
      end
   end

   always @(posedge sys_clk_i)
   begin
      if (irq_ack_i && !ack_seen && sp < STACK_DEPTH[4:0])
         stack_mem[sp] <= pc_i;
   end

   ////////////////////////////////////////////////////////////////////
   // Avalon slave: one wait state per access
   always @*
   begin
      next_rdata = 32'h00000000;
      case (avs_address_i)
         `ISR_OFS_RESET_CTRL:
            next_rdata = {24'h000000, reset_cause_and_priority_control & 8'hDF};
         `ISR_OFS_IRQ_FIRST:
            next_rdata = {24'h000000, c1};
         `ISR_OFS_IRQ_SECOND:
            next_rdata = {24'h000000, c2};
         `ISR_OFS_IRQ_THIRD:
            next_rdata = {24'h000000, c3};
         `ISR_OFS_TIMER:
            next_rdata = {14'h0000, tm_run, tm_wide, tmr};
         `ISR_OFS_CONTEXT:
            next_rdata = {8'h00, shadow};
         `ISR_OFS_STATUS:
            next_rdata = {27'h0000000, sp};
         default:
            next_rdata = 32'h00000000;
      endcase
   end

   always @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h00000000;
      end
      else
      begin
         avs_waitrequest_o <= ~((avs_read_i | avs_write_i) &
            avs_waitrequest_o);
         if (rd)
            avs_readdata_o <= next_rdata;
      end
   end
endmodule // isr_ctrl

/* File: tb/isr_core_model.sv */
// Core model: takes vectors after a set delay and offers context
`timescale 1ns/1ns
module isr_core_model
(
   // Clock and reset
   input wire sys_clk_i,
   input wire rst_b_i,
   // Request and answer
   input wire irq_i,
   input wire [3:0] delay_i,
   output reg irq_ack_o,
   output wire [23:0] ctx_o
);
   reg [3:0] cnt;
   // Fixed context so the shadow copy is predictable
   assign ctx_o = 24'hA53C0F;
   always @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         cnt <= 4'h0;
         irq_ack_o <= 1'b0;
      end
      else
      begin
         // Delay must outlast the request drop, or it acks twice
         irq_ack_o <= irq_i && !irq_ack_o && cnt == delay_i;
         cnt <= (irq_i && !irq_ack_o && cnt != delay_i) ? cnt + 4'h1 : 4'h0;
      end
   end
endmodule // isr_core_model

/* File: tb/isr_ctrl_assertions.sv */
// Port checks of the interrupt block
`timescale 1ns/1ns
module isr_ctrl_chk
(
   // Clock and reset
   input wire sys_clk_i,
   input wire rst_b_i,
   // Bus
   input wire [3:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_readdata_o,
   input wire avs_waitrequest_o,
   // Requests
   input wire irq_ack_i,
   input wire irq_high_o,
   input wire irq_low_o
);
   wire req = (avs_read_i || avs_write_i) && avs_waitrequest_o;
   wire rd = avs_read_i && avs_waitrequest_o;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   ////////////////////////////////////////
   wait_answer_a: assert property (req |=> !avs_waitrequest_o)
      else $error("bus request not answered next cycle");
   wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low longer than one cycle");
   data_hold_a: assert property (!rd |=> $stable(avs_readdata_o))
      else $error("read data moved without a read");
   unmapped_zero_a: assert property
      (rd && avs_address_i > 4'h6 |=> avs_readdata_o == 32'h0)
      else $error("unmapped address read nonzero");
   rc_bit5_a: assert property
      (rd && avs_address_i == 4'h0 |=> !avs_readdata_o[5])
      else $error("reset control bit 5 read nonzero");
   third_res_a: assert property (rd && avs_address_i == 4'h3 |=>
      avs_readdata_o[31:8] == 24'h0 && avs_readdata_o[5:5] == 1'b0)
      else $error("third control reserved bits nonzero");
   ack_mask_a: assert property
      ($rose(irq_ack_i) && irq_high_o |-> ##[1:3] !irq_high_o)
      else $error("high request stayed after acknowledge");
   reset_vals_a: assert property (disable iff (1'b0)
      !rst_b_i |-> avs_waitrequest_o && !irq_high_o && !irq_low_o)
      else $error("outputs not at reset values");
   cover property (avs_write_i && !avs_waitrequest_o);
   cover property (rd && avs_address_i == 4'h5);
   cover property ($rose(irq_high_o));
   cover property ($rose(irq_low_o));
endmodule // isr_ctrl_chk
bind isr_ctrl isr_ctrl_chk u_chk
(
   .sys_clk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i,
   .avs_readdata_o, .avs_waitrequest_o, .irq_ack_i, .irq_high_o,
   .irq_low_o
);

/* File: tb/tb.sv */
// Self-checking bench for the interrupt block
`timescale 1ns/1ns
module tb;
   reg sys_clk_i = 1'b0, rst_b_i = 1'b1, cfg_soft_bor_i = 1'b1;
   reg cause_por_i = 1'b1, cause_wdt_i = 1'b0, cause_rst_instr_i = 1'b0;
   reg sleep_i = 1'b0, peripheral_irq_i = 1'b0;
   reg avs_read_i = 1'b0, avs_write_i = 1'b0;
   reg [2:0] ext_pin_i = 3'h0;
   reg [3:0] portb_hi_i = 4'h0, avs_address_i = 4'h0, dly = 4'h3;
   reg [31:0] avs_writedata_i = 32'h0, q;
   wire [31:0] avs_readdata_o;
   wire avs_waitrequest_o, irq_high_o, irq_low_o, wake_o, vector_o, ack;
   wire [23:0] ctx;
   integer miscompares = 0, tests_run = 0, i, k;
   reg [19:0] rows [0:6] = '{20'h0000C, 20'h0FFDF, 20'h2FFF5, 20'h3D8D8,
      20'h17878, 20'h7FF00, 20'hFFF00};
   reg [7:0] rv [0:3] = '{8'h5C, 8'h00, 8'hF5, 8'hC0};
   always #20 sys_clk_i = ~sys_clk_i;
   isr_ctrl dut
   (
      .sys_clk_i, .rst_b_i, .cfg_soft_bor_i, .cause_por_i,
      .cause_bor_i(1'b0), .cause_wdt_i, .cause_rst_instr_i, .sleep_i,
      .ext_pin_i, .portb_hi_i, .peripheral_irq_i, .irq_ack_i(ack),
      .pc_i(21'h01234), .working_accumulator_i(ctx[23:16]), .status_i(ctx[15:8]),
      .bsr_i(ctx[7:0]), .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
      .irq_high_o, .irq_low_o, .wake_o, .vector_o
   );
   isr_core_model u_core
   (
      .sys_clk_i, .rst_b_i, .irq_i(irq_high_o | irq_low_o),
      .delay_i(dly), .irq_ack_o(ack), .ctx_o(ctx)
   );
   ////////////////////////////////////////
   task finish_test;
      begin
         $display("Checks %0d, mismatches %0d", tests_run, miscompares);
         if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task chk(input string nm, input [31:0] e, input [31:0] s);
      begin
         tests_run = tests_run + 1;
         if (s !== e)
         begin
            miscompares = miscompares + 1;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
         end
      end
   endtask
   task tmo;
      begin
         chk("timeout", 32'h0, 32'h1);
         finish_test;
      end
   endtask
   // Request held until the edge that sees waitrequest low
   task bus(input [3:0] a, input w, input [31:0] d);
      integer n;
      begin
         @(posedge sys_clk_i);
         avs_address_i <= a;
         avs_write_i <= w;
         avs_read_i <= !w;
         avs_writedata_i <= d;
         n = 0;
         @(posedge sys_clk_i);
         while (avs_waitrequest_o !== 1'b0 && n < 20)
         begin
            n = n + 1;
            @(posedge sys_clk_i);
         end
         q = avs_readdata_o;
         avs_read_i <= 1'b0;
         avs_write_i <= 1'b0;
         if (n == 20)
            tmo;
      end
   endtask
   task wr(input [3:0] a, input [31:0] d);
      bus(a, 1'b1, d);
   endtask
   task rd(input [3:0] a);
      bus(a, 1'b0, 32'h0);
   endtask
   task irq_wait;
      integer n;
      begin
         n = 0;
         while ({irq_high_o, irq_low_o, wake_o} === 3'h0 && n < 30)
         begin
            n = n + 1;
            @(negedge sys_clk_i);
         end
         if (n == 30)
            tmo;
      end
   endtask
   // Polarity first, then clear: the flag left by the previous step is cleared
   task ext(input integer i, input b, input pol, input e);
      reg [31:0] q1;
      begin
         wr(4'h2, pol ? 32'hF5 : 32'hF5 & ~(32'h40 >> i));
         wr(4'h1, 32'h0);
         wr(4'h3, 32'hC0);
         ext_pin_i[i] <= b;
         repeat (6) @(posedge sys_clk_i);
         rd(4'h1);
         q1 = q;
         rd(4'h3);
         chk("ext_flag", {31'h0, e}, {31'h0, i ? q[i-1] : q1[1]});
      end
   endtask
   task reset_dut;
      begin
         rst_b_i <= 1'b0;
         repeat (4) @(posedge sys_clk_i);
         rst_b_i <= 1'b1;
         repeat (2) @(posedge sys_clk_i);
      end
   endtask
   ////////////////////////////////////////
   initial
   begin
      reset_dut;
      for (i = 0; i < 4; i = i + 1)
      begin
         rd(i[3:0]);
         chk("reset_value", {24'h0, rv[i]}, q);
      end
      for (i = 0; i < 7; i = i + 1)
      begin
         wr(rows[i][19:16], {24'h0, rows[i][15:8]});
         rd(rows[i][19:16]);
         chk("reg_rw", {24'h0, rows[i][7:0]}, q);
      end
      cause_wdt_i <= 1'b1;
      cause_rst_instr_i <= 1'b1;
      cause_por_i <= 1'b0;
      cfg_soft_bor_i <= 1'b0;
      reset_dut;
      rd(4'h0);
      chk("reset_cause", 32'h07, q);
      for (i = 0; i < 3; i = i + 1)
      begin
         ext(i, 1'b1, 1'b1, 1'b1);
         ext(i, 1'b0, 1'b0, 1'b1);
         ext(i, 1'b1, 1'b0, 1'b0);
         ext(i, 1'b0, 1'b1, 1'b0);
      end
      for (k = 0; k < 4; k = k + 1)
      begin
         wr(4'h1, 32'h0);
         portb_hi_i[k] <= 1'b1;
         repeat (6) @(posedge sys_clk_i);
         rd(4'h1);
         chk("change_flag", 32'h1, q);
      end
      for (k = 0; k < 2; k = k + 1)
      begin
         wr(4'h1, 32'h0);
         wr(4'h4, k ? 32'h0003FFFE : 32'h000202FE);
         repeat (6) @(posedge sys_clk_i);
         wr(4'h4, 32'h0);
         rd(4'h1);
         chk("timer_flag", 32'h4, q);
      end
      wr(4'h0, 32'h80);
      wr(4'h2, 32'hF1);
      wr(4'h1, 32'hE4);
      irq_wait;
      chk("irq_t0", 32'h1, {30'h0, irq_high_o, irq_low_o});
      repeat (8) @(posedge sys_clk_i);
      wr(4'h1, 32'h90);
      ext_pin_i[0] <= 1'b1;
      irq_wait;
      chk("irq_x0", 32'h2, {30'h0, irq_high_o, irq_low_o});
      repeat (8) @(posedge sys_clk_i);
      rd(4'h5);
      chk("shadow", 32'h00A53C0F, q);
      rd(4'h6);
      chk("stack_ptr", 32'h2, q);
      wr(4'h3, 32'h08);
      wr(4'h1, 32'hC0);
      ext_pin_i[1] <= 1'b1;
      irq_wait;
      chk("irq_x1", 32'h1, {30'h0, irq_high_o, irq_low_o});
      dly <= 4'h9;
      wr(4'h3, 32'h0);
      wr(4'h0, 32'h0);
      peripheral_irq_i <= 1'b1;
      wr(4'h1, 32'h80);
      repeat (4) @(negedge sys_clk_i);
      chk("irq_off", 32'h0, {30'h0, irq_high_o, irq_low_o});
      wr(4'h1, 32'hC0);
      irq_wait;
      chk("irq_legacy", 32'h2, {30'h0, irq_high_o, irq_low_o});
      peripheral_irq_i <= 1'b0;
      wr(4'h3, 32'h10);
      wr(4'h1, 32'h0);
      sleep_i <= 1'b1;
      rd(4'h0);
      chk("powerdown", 32'h0, q & 32'h4);
      ext_pin_i[2] <= 1'b1;
      irq_wait;
      chk("wake", 32'h2, {30'h0, wake_o, vector_o});
      wr(4'h1, 32'h80);
      repeat (2) @(negedge sys_clk_i);
      chk("vector", 32'h3, {30'h0, wake_o, vector_o});
      finish_test;
   end
endmodule // tb
